// ===== bench/sad_spad_model.sv
// Scratchpad memory model that answers the load/store unit's read strobe
`timescale 1ns/1ps
`default_nettype none
module sad_spad_model (
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic sp_rd_i,
   input wire logic [63:0] pa_i,
   output logic [63:0] sp_rdata_o
);
   // Pattern mixed into every answer
   localparam logic [63:0] SALT = 64'h5a5a_0f0f_3c3c_a5a5;
   // Data stands in the cycle after the strobe, scrambled otherwise
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         sp_rdata_o <= 64'h0;
      end else if (sp_rd_i) begin
         sp_rdata_o <= pa_i ^ SALT;
      end else begin
         // Released bus inverts every cycle, so it repeats every second cycle
         sp_rdata_o <= ~sp_rdata_o;
      end
   end
endmodule
`default_nettype wire

// ===== bench/segment_access_decode_tb.sv
// Self-checking bench for the segment access decode core
`timescale 1ns/1ps
`default_nettype none
module segment_access_decode_tb;
   import sad_pkg::*;
   // Expected pulse vector: io, mem, tlb, sp_rd, sp_wr, dma, err
   localparam logic [6:0] V_IO = 7'h40, V_MEM = 7'h20, V_TLB = 7'h10, V_SPR = 7'h08;
   localparam logic [6:0] V_SPW = 7'h04, V_DMA = 7'h02, V_ERR = 7'h01;
   localparam logic [63:0] SALT = 64'h5a5a_0f0f_3c3c_a5a5;
   logic CLK_I = 1'b0, NRST_I = 1'b0;
   logic LS_VALID_I = 1'b0, LS_STORE_I = 1'b0, LS_ADDR32_I = 1'b0;
   logic [1:0] LS_MODE_I = 2'h0;
   logic [63:0] LS_ADDR_I = 64'h0, LS_WDATA_I = 64'h0, SP_RDATA_I, PA_O, WDATA_O, LD_DATA_O;
   logic [3:0] REG_ADDR_I = 4'h0;
   logic [31:0] REG_WDATA_I = 32'h0, REG_RDATA_O;
   logic REG_WR_I = 1'b0, REG_RD_I = 1'b0;
   logic IO_REQ_O, MEM_REQ_O, TLB_REQ_O, SP_RD_O, SP_WR_O, DMA_START_O, STORE_O, ERR_O;
   logic LD_VALID_O;
   logic [2:0] ERR_CAUSE_O;
   int n_fail = 0, total_checks = 0;
   // Clock at 50 MHz
   always #10 CLK_I = ~CLK_I;
   sad_core DUT (.CLK_I(CLK_I), .NRST_I(NRST_I), .LS_VALID_I(LS_VALID_I),
      .LS_STORE_I(LS_STORE_I), .LS_MODE_I(LS_MODE_I), .LS_ADDR_I(LS_ADDR_I),
      .LS_ADDR32_I(LS_ADDR32_I), .LS_WDATA_I(LS_WDATA_I), .SP_RDATA_I(SP_RDATA_I),
      .REG_ADDR_I(REG_ADDR_I), .REG_WDATA_I(REG_WDATA_I), .REG_WR_I(REG_WR_I),
      .REG_RD_I(REG_RD_I), .REG_RDATA_O(REG_RDATA_O), .IO_REQ_O(IO_REQ_O),
      .MEM_REQ_O(MEM_REQ_O), .TLB_REQ_O(TLB_REQ_O), .SP_RD_O(SP_RD_O), .SP_WR_O(SP_WR_O),
      .DMA_START_O(DMA_START_O), .STORE_O(STORE_O), .PA_O(PA_O), .WDATA_O(WDATA_O),
      .ERR_O(ERR_O), .ERR_CAUSE_O(ERR_CAUSE_O), .LD_VALID_O(LD_VALID_O),
      .LD_DATA_O(LD_DATA_O));
   // Scratchpad partner
   sad_spad_model spad (.clk_i(CLK_I), .nrst_i(NRST_I), .sp_rd_i(SP_RD_O), .pa_i(PA_O),
      .sp_rdata_o(SP_RDATA_I));
   // Compare and count
   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // Verdict and end of run
   task automatic conclude();
      $display("checks=%0d mismatches=%0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   // Register write, one strobe cycle
   task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
      REG_ADDR_I <= a;
      REG_WDATA_I <= d;
      REG_WR_I <= 1'b1;
      @(posedge CLK_I);
      REG_WR_I <= 1'b0;
   endtask
   // Register read, data in the following cycle only
   task automatic reg_rd(input logic [3:0] a, input logic [31:0] exp);
      REG_ADDR_I <= a;
      REG_RD_I <= 1'b1;
      @(posedge CLK_I);
      REG_RD_I <= 1'b0;
      #1 chk({32'h0, REG_RDATA_O}, {32'h0, exp});
      @(posedge CLK_I);
   endtask
   // One pipeline request, outcome checked the next cycle
   task automatic req(input logic st, input logic [1:0] md, input logic [63:0] a,
                      input logic a32, input logic [6:0] ev, input logic [2:0] ec,
                      input logic [63:0] epa);
      LS_VALID_I <= 1'b1;
      LS_STORE_I <= st;
      LS_MODE_I <= md;
      LS_ADDR_I <= a;
      LS_ADDR32_I <= a32;
      LS_WDATA_I <= ~a;
      @(posedge CLK_I);
      LS_VALID_I <= 1'b0;
      #1 chk({57'h0, IO_REQ_O, MEM_REQ_O, TLB_REQ_O, SP_RD_O, SP_WR_O, DMA_START_O, ERR_O},
             {57'h0, ev});
      chk({61'h0, ERR_CAUSE_O}, {61'h0, ec});
      chk(PA_O, epa);
      chk({63'h0, STORE_O}, {63'h0, st});
      chk(WDATA_O, ~a);
      @(posedge CLK_I);
   endtask
   // Mid-run reset clears outputs and enables
   task automatic t_reset();
      reg_wr(REG_CTRL, 32'h3f);
      NRST_I <= 1'b0;
      @(posedge CLK_I);
      #1 chk({20'h0, IO_REQ_O, MEM_REQ_O, TLB_REQ_O, SP_RD_O, SP_WR_O, DMA_START_O, ERR_O,
              ERR_CAUSE_O, STORE_O, LD_VALID_O, REG_RDATA_O}, 64'h0);
      chk(PA_O | WDATA_O | LD_DATA_O, 64'h0);
      @(posedge CLK_I);
      NRST_I <= 1'b1;
      @(posedge CLK_I);
      reg_rd(REG_CTRL, 32'h0);
      req(1'b0, MODE_USER, IO_LO, 1'b0, V_ERR, CAUSE_PRIV, IO_LO);
      $display("test reset done");
   endtask
   // Kernel register space and memory edges
   task automatic t_kernel();
      req(1'b0, MODE_KERNEL, IO_LO, 1'b0, V_IO, CAUSE_NONE, IO_LO);
      req(1'b1, MODE_KERNEL, IO_HI, 1'b0, V_IO, CAUSE_NONE, IO_HI);
      req(1'b0, MODE_KERNEL, IO_HI + 64'h1, 1'b0, V_ERR, CAUSE_NOPOP, IO_HI + 64'h1);
      req(1'b0, MODE_KERNEL, MEM_HI, 1'b0, V_MEM, CAUSE_NONE, MEM_HI);
      req(1'b1, MODE_KERNEL, MEM_HI + 64'h1, 1'b0, V_ERR, CAUSE_NOPOP, MEM_HI + 64'h1);
      $display("test kernel done");
   endtask
   // User and supervisor gating of the unmapped segment
   task automatic t_user();
      req(1'b0, MODE_USER, IO_LO, 1'b0, V_ERR, CAUSE_PRIV, IO_LO);
      reg_wr(REG_CTRL, 32'h1 << CTL_UIO);
      req(1'b0, MODE_USER, IO_LO, 1'b0, V_ERR, CAUSE_PRIV, IO_LO);
      reg_wr(REG_CTRL, (32'h1 << CTL_UIO) | (32'h1 << CTL_UX));
      req(1'b1, MODE_USER, IO_LO, 1'b0, V_IO, CAUSE_NONE, IO_LO);
      req(1'b0, MODE_USER, MEM_LO, 1'b0, V_ERR, CAUSE_PRIV, MEM_LO);
      reg_wr(REG_CTRL, (32'h1 << CTL_UMEM) | (32'h1 << CTL_UX));
      req(1'b0, MODE_USER, MEM_LO, 1'b0, V_MEM, CAUSE_NONE, MEM_LO);
      req(1'b1, MODE_USER, MEM_HI, 1'b0, V_MEM, CAUSE_NONE, MEM_HI);
      req(1'b0, MODE_USER, IO_LO, 1'b0, V_ERR, CAUSE_PRIV, IO_LO);
      req(1'b0, MODE_SUPER, MEM_LO, 1'b0, V_ERR, CAUSE_PRIV, MEM_LO);
      reg_wr(REG_CTRL, 32'h0);
      $display("test user done");
   endtask
   // Scratchpad and special window per mode
   task automatic t_windows();
      req(1'b0, MODE_KERNEL, SPAD_LO, 1'b0, V_TLB, CAUSE_NONE, SPAD_LO);
      reg_wr(REG_CTRL, 32'h1 << CTL_SWK);
      req(1'b0, MODE_KERNEL, SPAD_LO, 1'b0, V_SPR, CAUSE_NONE, SPAD_LO);
      @(posedge CLK_I);
      #1 chk({63'h0, LD_VALID_O}, 64'h1);
      chk(LD_DATA_O, SPAD_LO ^ SALT);
      @(posedge CLK_I);
      req(1'b1, MODE_KERNEL, SPAD_HI, 1'b0, V_SPW, CAUSE_NONE, SPAD_HI);
      req(1'b1, MODE_KERNEL, DMA_ADDR, 1'b0, V_DMA, CAUSE_NONE, DMA_ADDR);
      req(1'b0, MODE_KERNEL, DMA_ADDR, 1'b0, V_ERR, CAUSE_SWIN, DMA_ADDR);
      req(1'b1, MODE_KERNEL, SWIN_LO, 1'b0, V_ERR, CAUSE_SWIN, SWIN_LO);
      req(1'b1, MODE_KERNEL, SWIN_HI + 64'h1, 1'b0, V_TLB, CAUSE_NONE, SWIN_HI + 64'h1);
      req(1'b1, MODE_USER, SPAD_LO, 1'b0, V_ERR, CAUSE_PRIV, SPAD_LO);
      reg_wr(REG_CTRL, (32'h1 << CTL_SWU) | (32'h1 << CTL_SWS));
      req(1'b1, MODE_USER, SPAD_LO, 1'b0, V_SPW, CAUSE_NONE, SPAD_LO);
      req(1'b1, MODE_SUPER, DMA_ADDR, 1'b0, V_DMA, CAUSE_NONE, DMA_ADDR);
      req(1'b1, MODE_KERNEL, DMA_ADDR, 1'b0, V_TLB, CAUSE_NONE, DMA_ADDR);
      $display("test windows done");
   endtask
   // 32-bit address forms
   task automatic t_sext();
      reg_wr(REG_CTRL, 32'h1 << CTL_SWK);
      req(1'b1, MODE_KERNEL, 64'hffff_a200, 1'b1, V_DMA, CAUSE_NONE, DMA_ADDR);
      req(1'b1, MODE_KERNEL, 64'hffff_a200, 1'b0, V_TLB, CAUSE_NONE, 64'hffff_a200);
      req(1'b0, MODE_USER, 64'h1234_0000_8000_1000, 1'b1, V_TLB, CAUSE_NONE,
          64'hffff_ffff_8000_1000);
      req(1'b0, MODE_KERNEL, 64'hffff_ffff_7fff_0010, 1'b1, V_TLB, CAUSE_NONE,
          64'h7fff_0010);
      $display("test sext done");
   endtask
   // Register access kinds and event counters
   task automatic t_regs();
      reg_wr(REG_CTRL, 32'hffff_ffff);
      reg_wr(4'h8, 32'h0);
      reg_rd(REG_CTRL, 32'h3f);
      reg_rd(4'hc, 32'h0);
      reg_wr(REG_STAT, 32'h0);
      req(1'b1, MODE_KERNEL, DMA_ADDR, 1'b0, V_DMA, CAUSE_NONE, DMA_ADDR);
      req(1'b1, MODE_KERNEL, DMA_ADDR, 1'b0, V_DMA, CAUSE_NONE, DMA_ADDR);
      req(1'b0, MODE_KERNEL, IO_HI + 64'h1, 1'b0, V_ERR, CAUSE_NOPOP, IO_HI + 64'h1);
      reg_rd(REG_STAT, 32'h0002_0001);
      $display("test regs done");
   endtask
   // Hang guard
   initial begin
      #200000;
      n_fail++;
      conclude();
   end
   // Main sequence
   initial begin
      repeat (2) @(posedge CLK_I);
      NRST_I <= 1'b1;
      @(posedge CLK_I);
      reg_rd(REG_CTRL, 32'h0);
      t_kernel();
      t_user();
      t_windows();
      t_sext();
      t_regs();
      t_reset();
      conclude();
   end
endmodule
`default_nettype wire

// ===== inc/sad_pkg.sv
// Constants, types and helpers shared by the segment access decode block
package sad_pkg;
   // Address windows
   localparam logic [63:0] IO_LO = 64'h8001_0000_0000_0000;
   localparam logic [63:0] IO_HI = 64'h8001_6700_0000_03ff;
   localparam logic [63:0] MEM_LO = 64'h8000_0000_0000_0000;
   localparam logic [63:0] MEM_HI = 64'h8000_0004_1fff_ffff;
   localparam logic [63:0] SPAD_LO = 64'hffff_ffff_ffff_8000;
   localparam logic [63:0] SPAD_HI = 64'hffff_ffff_ffff_9fff;
   localparam logic [63:0] SWIN_LO = 64'hffff_ffff_ffff_a000;
   localparam logic [63:0] SWIN_HI = 64'hffff_ffff_ffff_bfff;
   localparam logic [63:0] DMA_ADDR = 64'hffff_ffff_ffff_a200;
   // Unmapped segment tag and field positions
   localparam logic [1:0] XKPHYS_TAG = 2'h2;
   localparam int XK_IO_BIT = 48;
   localparam int UNIT_MSB = 46;
   localparam int UNIT_LSB = 40;
   localparam int SEXT_BIT = 31;
   // Privilege modes
   localparam logic [1:0] MODE_KERNEL = 2'h0;
   localparam logic [1:0] MODE_SUPER = 2'h1;
   localparam logic [1:0] MODE_USER = 2'h2;
   // Error causes
   localparam logic [2:0] CAUSE_NONE = 3'h0;
   localparam logic [2:0] CAUSE_PRIV = 3'h1;
   localparam logic [2:0] CAUSE_NOPOP = 3'h2;
   localparam logic [2:0] CAUSE_SWIN = 3'h3;
   // Register offsets and control fields
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_STAT = 4'h4;
   localparam int CTL_UIO = 0;
   localparam int CTL_UMEM = 1;
   localparam int CTL_SWK = 2;
   localparam int CTL_SWS = 3;
   localparam int CTL_SWU = 4;
   localparam int CTL_UX = 5;
   localparam int CTRL_W = 6;
   localparam logic [5:0] CTRL_RST = 6'h00;
   localparam int CNT_W = 16;
   // Segment classes
   typedef enum logic [2:0] {SEG_OTHER, SEG_XKIO, SEG_XKMEM, SEG_SPAD, SEG_SWIN} sad_seg_e;
   // Inclusive range test
   function automatic logic sad_in_range(input logic [63:0] a, input logic [63:0] lo,
                                         input logic [63:0] hi);
      sad_in_range = (a >= lo) && (a <= hi);
   endfunction
endpackage

// ===== verilog/sad_classify.sv
// Address extension and segment classification
`timescale 1ns/1ps
`default_nettype none
module sad_classify #(
   parameter logic [127:0] IO_UNIT_MASK = {128{1'b1}},
   parameter logic [63:0] MEM_TOP = sad_pkg::MEM_HI
) (
   input wire logic [63:0] addr_i,
   input wire logic addr32_i,
   output logic [63:0] eff_addr_o,
   output sad_pkg::sad_seg_e seg_o,
   output logic populated_o,
   output logic dma_addr_o
);
   import sad_pkg::*;

   // Extension, class and population decode
   always_comb begin
      if (addr32_i) begin
         eff_addr_o = {{32{addr_i[SEXT_BIT]}}, addr_i[SEXT_BIT:0]};
      end else begin
         eff_addr_o = addr_i;
      end
      dma_addr_o = (eff_addr_o == DMA_ADDR);
      seg_o = SEG_OTHER;
      populated_o = 1'b1;
      if (eff_addr_o[63:62] == XKPHYS_TAG) begin
         if (eff_addr_o[XK_IO_BIT]) begin
            seg_o = SEG_XKIO;
            populated_o = sad_in_range(eff_addr_o, IO_LO, IO_HI) &&
                          IO_UNIT_MASK[eff_addr_o[UNIT_MSB:UNIT_LSB]];
         end else begin
            seg_o = SEG_XKMEM;
            populated_o = sad_in_range(eff_addr_o, MEM_LO, MEM_TOP);
         end
      end else if (sad_in_range(eff_addr_o, SPAD_LO, SPAD_HI)) begin
         seg_o = SEG_SPAD;
      end else if (sad_in_range(eff_addr_o, SWIN_LO, SWIN_HI)) begin
         seg_o = SEG_SWIN;
         populated_o = dma_addr_o;
      end
   end
endmodule
`default_nettype wire

// ===== verilog/sad_core.sv
// Load/store segment decode, privilege gating and routing
//
// Our own choices: strobed register access and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module sad_core #(
   parameter logic [127:0] IO_UNIT_MASK = {128{1'b1}},
   parameter logic [63:0] MEM_TOP = sad_pkg::MEM_HI
) (
   input wire logic CLK_I,
   input wire logic NRST_I,
   // Pipeline request
   input wire logic LS_VALID_I,
   input wire logic LS_STORE_I,
   input wire logic [1:0] LS_MODE_I,
   input wire logic [63:0] LS_ADDR_I,
   input wire logic LS_ADDR32_I,
   input wire logic [63:0] LS_WDATA_I,
   // Scratchpad read data, one cycle after read strobe
   input wire logic [63:0] SP_RDATA_I,
   // Register port
   input wire logic [3:0] REG_ADDR_I,
   input wire logic [31:0] REG_WDATA_I,
   input wire logic REG_WR_I,
   input wire logic REG_RD_I,
   output logic [31:0] REG_RDATA_O,
   // Routed requests
   output logic IO_REQ_O,
   output logic MEM_REQ_O,
   output logic TLB_REQ_O,
   output logic SP_RD_O,
   output logic SP_WR_O,
   output logic DMA_START_O,
   output logic STORE_O,
   output logic [63:0] PA_O,
   output logic [63:0] WDATA_O,
   // Address error
   output logic ERR_O,
   output logic [2:0] ERR_CAUSE_O,
   // Scratchpad load answer
   output logic LD_VALID_O,
   output logic [63:0] LD_DATA_O
);
   import sad_pkg::*;

   // Whole state of the block
   typedef struct packed {
      logic [CTRL_W-1:0] ctrl;   // Enable bits
      logic [CNT_W-1:0] err_cnt; // Address errors seen
      logic [CNT_W-1:0] dma_cnt; // DMA launches seen
      logic [31:0] rdata;        // Register read data
      logic io_req;              // I/O space request
      logic mem_req;             // Memory request
      logic tlb_req;             // Translated path request
      logic sp_rd;               // Scratchpad read
      logic sp_wr;               // Scratchpad write
      logic dma;                 // Block DMA launch
      logic err;                 // Address error
      logic [2:0] cause;         // Error cause
      logic store;               // Access is a store
      logic [63:0] pa;           // Physical address
      logic [63:0] wdata;        // Store data
      logic rd_pend;             // Scratchpad data due
      logic ld_valid;            // Load answer valid
      logic [63:0] ld_data;      // Load answer data
   } sad_state_s;

   localparam sad_state_s ST_RST = '0;

   sad_state_s s_r;   // Registered state
   sad_state_s s_nxt; // Next state

   logic [63:0] eff_addr;  // Extended address
   sad_seg_e seg;          // Segment class
   logic populated;        // Address is backed
   logic dma_addr;         // Launch address hit
   logic allow;            // Privilege allows access
   logic swin_on;          // Window enable for mode

   // Address extension and classification
   sad_classify #(
      .IO_UNIT_MASK(IO_UNIT_MASK),
      .MEM_TOP(MEM_TOP)
   ) u_classify (
      .addr_i(LS_ADDR_I),
      .addr32_i(LS_ADDR32_I),
      .eff_addr_o(eff_addr),
      .seg_o(seg),
      .populated_o(populated),
      .dma_addr_o(dma_addr)
   );

   // Privilege check
   sad_permit u_permit (
      .mode_i(LS_MODE_I),
      .seg_i(seg),
      .user_io_segment_enable_i(s_r.ctrl[CTL_UIO]),
      .user_memory_segment_enable_i(s_r.ctrl[CTL_UMEM]),
      .special_window_enables_i(s_r.ctrl[CTL_SWU:CTL_SWK]),
      .user_64bit_i(s_r.ctrl[CTL_UX]),
      .allow_o(allow),
      .swin_on_o(swin_on)
   );

   // Next state
   always_comb begin
      s_nxt = s_r;
      // Pulses last one cycle
      s_nxt.io_req = 1'b0;
      s_nxt.mem_req = 1'b0;
      s_nxt.tlb_req = 1'b0;
      s_nxt.sp_rd = 1'b0;
      s_nxt.sp_wr = 1'b0;
      s_nxt.dma = 1'b0;
      s_nxt.err = 1'b0;
      s_nxt.ld_valid = 1'b0;
      s_nxt.rdata = '0;
      s_nxt.rd_pend = s_r.sp_rd;
      if (s_r.rd_pend) begin
         s_nxt.ld_valid = 1'b1;
         s_nxt.ld_data = SP_RDATA_I;
      end
      // Register writes
      if (REG_WR_I) begin
         case (REG_ADDR_I)
            REG_CTRL: s_nxt.ctrl = REG_WDATA_I[CTRL_W-1:0];
            REG_STAT: begin
               // Clear counters, new events below still count
               s_nxt.err_cnt = '0;
               s_nxt.dma_cnt = '0;
            end
            default: ;
         endcase
      end
      // Register reads, data only in next cycle
      if (REG_RD_I) begin
         case (REG_ADDR_I)
            REG_CTRL: s_nxt.rdata = {{(32-CTRL_W){1'b0}}, s_r.ctrl};
            REG_STAT: s_nxt.rdata = {s_r.dma_cnt, s_r.err_cnt};
            default: s_nxt.rdata = '0;
         endcase
      end
      // Access decode
      if (LS_VALID_I) begin
         s_nxt.pa = eff_addr;
         s_nxt.store = LS_STORE_I;
         s_nxt.wdata = LS_WDATA_I;
         s_nxt.cause = CAUSE_NONE;
         if (!allow) begin
            s_nxt.err = 1'b1;
            s_nxt.cause = CAUSE_PRIV;
         end else begin
            case (seg)
               SEG_XKIO: begin
                  if (populated) begin
                     s_nxt.io_req = 1'b1;
                  end else begin
                     s_nxt.err = 1'b1;
                     s_nxt.cause = CAUSE_NOPOP;
                  end
               end
               SEG_XKMEM: begin
                  if (populated) begin
                     s_nxt.mem_req = 1'b1;
                  end else begin
                     s_nxt.err = 1'b1;
                     s_nxt.cause = CAUSE_NOPOP;
                  end
               end
               SEG_SPAD: begin
                  if (!swin_on) begin
                     s_nxt.tlb_req = 1'b1;
                  end else if (LS_STORE_I) begin
                     s_nxt.sp_wr = 1'b1;
                  end else begin
                     s_nxt.sp_rd = 1'b1;
                  end
               end
               SEG_SWIN: begin
                  if (!swin_on) begin
                     s_nxt.tlb_req = 1'b1;
                  end else if (LS_STORE_I && dma_addr) begin
                     s_nxt.dma = 1'b1;
                  end else begin
                     s_nxt.err = 1'b1;
                     s_nxt.cause = CAUSE_SWIN;
                  end
               end
               default: s_nxt.tlb_req = 1'b1;
            endcase
         end
      end
      // Event counters
      if (s_nxt.err) begin
         s_nxt.err_cnt = s_nxt.err_cnt + 1'b1;
      end
      if (s_nxt.dma) begin
         s_nxt.dma_cnt = s_nxt.dma_cnt + 1'b1;
      end
   end

   // State register
   always_ff @(posedge CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         s_r <= ST_RST;
      end else begin
         s_r <= s_nxt;
      end
   end

   // Outputs straight from state
   assign REG_RDATA_O = s_r.rdata;
   assign IO_REQ_O = s_r.io_req;
   assign MEM_REQ_O = s_r.mem_req;
   assign TLB_REQ_O = s_r.tlb_req;
   assign SP_RD_O = s_r.sp_rd;
   assign SP_WR_O = s_r.sp_wr;
   assign DMA_START_O = s_r.dma;
   assign STORE_O = s_r.store;
   assign PA_O = s_r.pa;
   assign WDATA_O = s_r.wdata;
   assign ERR_O = s_r.err;
   assign ERR_CAUSE_O = s_r.cause;
   assign LD_VALID_O = s_r.ld_valid;
   assign LD_DATA_O = s_r.ld_data;

   // Helper terms for the checks
   logic is_user;     // User mode request
   logic is_kern;     // Kernel mode request
   logic user_ux;     // User 64-bit addressing on
   logic any_route;   // Any routed request
   assign is_user = LS_VALID_I && (LS_MODE_I == MODE_USER);
   assign is_kern = LS_VALID_I && (LS_MODE_I == MODE_KERNEL);
   assign user_ux = s_r.ctrl[CTL_UX];
   assign any_route = IO_REQ_O || MEM_REQ_O || TLB_REQ_O || SP_RD_O || SP_WR_O || DMA_START_O;

   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (!NRST_I);

   // I/O requests stay inside register space
   property p_io_range;
      IO_REQ_O |-> (PA_O >= IO_LO) && (PA_O <= IO_HI);
   endproperty
   a_io_range: assert property (p_io_range)
      else $error("io request outside register space");

   // Missing unit gives error
   property p_io_hole;
      LS_VALID_I && allow && (seg == SEG_XKIO) && !populated
         |=> ERR_O && (ERR_CAUSE_O == CAUSE_NOPOP) && !IO_REQ_O;
   endproperty
   a_io_hole: assert property (p_io_hole)
      else $error("unpopulated io address not refused");

   // Untranslated route carries extended address
   property p_bypass;
      (IO_REQ_O || MEM_REQ_O) |-> !TLB_REQ_O && (PA_O == $past(eff_addr));
   endproperty
   a_bypass: assert property (p_bypass)
      else $error("unmapped access altered or translated");

   // User without 64-bit addressing refused
   property p_user_refuse;
      is_user && ((seg == SEG_XKIO) || (seg == SEG_XKMEM)) && !user_ux
         |=> ERR_O && (ERR_CAUSE_O == CAUSE_PRIV);
   endproperty
   a_user_refuse: assert property (p_user_refuse)
      else $error("user access to kernel segment not refused");

   // User I/O opened by enable
   property p_user_io;
      is_user && (seg == SEG_XKIO) && populated && s_r.ctrl[CTL_UIO] && user_ux |=> IO_REQ_O;
   endproperty
   a_user_io: assert property (p_user_io)
      else $error("enabled user io access not routed");

   // User memory opened by enable
   property p_user_mem;
      is_user && (seg == SEG_XKMEM) && populated && s_r.ctrl[CTL_UMEM] && user_ux |=> MEM_REQ_O;
   endproperty
   a_user_mem: assert property (p_user_mem)
      else $error("enabled user memory access not routed");

   // Kernel I/O to a populated address always routed
   property p_kern_io;
      is_kern && (seg == SEG_XKIO) && populated |=> IO_REQ_O && !ERR_O;
   endproperty
   a_kern_io: assert property (p_kern_io)
      else $error("kernel io access not routed");

   // Memory requests stay below the top
   property p_mem_range;
      MEM_REQ_O |-> (PA_O >= MEM_LO) && (PA_O <= MEM_TOP) && !PA_O[XK_IO_BIT];
   endproperty
   a_mem_range: assert property (p_mem_range)
      else $error("memory request outside memory range");

   // DMA only from a store to the launch address
   property p_dma;
      DMA_START_O |-> STORE_O && (PA_O == DMA_ADDR) && !SP_WR_O && !MEM_REQ_O;
   endproperty
   a_dma: assert property (p_dma)
      else $error("dma launch without launch store");

   // Scratchpad data returned two cycles on
   property p_spad_load;
      SP_RD_O |-> ##2 LD_VALID_O && (LD_DATA_O == $past(SP_RDATA_I));
   endproperty
   a_spad_load: assert property (p_spad_load)
      else $error("scratchpad load answer missing");

   // Window handling only with mode enable
   property p_swin_en;
      (SP_RD_O || SP_WR_O || DMA_START_O) |-> $past(swin_on);
   endproperty
   a_swin_en: assert property (p_swin_en)
      else $error("window handling without enable");

   // 32-bit addresses sign extend
   property p_sext;
      LS_ADDR32_I |-> (eff_addr[63:32] == {32{LS_ADDR_I[SEXT_BIT]}});
   endproperty
   a_sext: assert property (p_sext)
      else $error("32-bit address not sign extended");

   // Kernel window access with enable off goes translated
   property p_win_off;
      is_kern && ((seg == SEG_SPAD) || (seg == SEG_SWIN)) && !swin_on
         |=> TLB_REQ_O && !ERR_O;
   endproperty
   a_win_off: assert property (p_win_off)
      else $error("kernel window access with enable off not translated");

   // Enabled scratchpad load strobes a scratchpad read
   property p_spad_rd;
      LS_VALID_I && !LS_STORE_I && allow && (seg == SEG_SPAD) && swin_on
         |=> SP_RD_O && !ERR_O;
   endproperty
   a_spad_rd: assert property (p_spad_rd)
      else $error("enabled scratchpad load not sent to scratchpad");

   // Error blocks every route
   property p_err_block;
      ERR_O |-> !any_route;
   endproperty
   a_err_block: assert property (p_err_block)
      else $error("refused access still routed");
endmodule
`default_nettype wire

// ===== verilog/sad_permit.sv
// Privilege gating per segment class and mode
`timescale 1ns/1ps
`default_nettype none
module sad_permit (
   input wire logic [1:0] mode_i,
   input wire sad_pkg::sad_seg_e seg_i,
   input wire logic user_io_segment_enable_i,
   input wire logic user_memory_segment_enable_i,
   input wire logic [2:0] special_window_enables_i,
   input wire logic user_64bit_i,
   output logic allow_o,
   output logic swin_on_o
);
   import sad_pkg::*;

   // Window enable pick and permission
   always_comb begin
      logic kern;
      logic user;
      kern = (mode_i == MODE_KERNEL);
      user = (mode_i == MODE_USER);
      case (mode_i)
         MODE_KERNEL: swin_on_o = special_window_enables_i[0];
         MODE_SUPER: swin_on_o = special_window_enables_i[1];
         MODE_USER: swin_on_o = special_window_enables_i[2];
         default: swin_on_o = 1'b0;
      endcase
      case (seg_i)
         SEG_XKIO: allow_o = kern || (user && user_io_segment_enable_i && user_64bit_i);
         SEG_XKMEM: allow_o = kern || (user && user_memory_segment_enable_i && user_64bit_i);
         SEG_SPAD, SEG_SWIN: allow_o = kern || swin_on_o;
         default: allow_o = 1'b1;
      endcase
   end
endmodule
`default_nettype wire
